// [pkg/nand_otp_host_cfg.svh]
// Constants for the parallel NAND host that runs the one-time area commands.
// Assumes a 20 MHz controller clock; every cycle count below except RE_LOW_CYC derives from it.
`ifndef NAND_OTP_HOST_CFG_SVH
`define NAND_OTP_HOST_CFG_SVH

// Clock period of the controller.
`define CLK_PERIOD_NS 50

// Opcodes placed on the data pins during command latch cycles.
`define OPC_RESET 8'hFF
`define OPC_STATUS 8'h70
`define OPC_LOCK 8'hA5
`define OPC_LOCK_CONFIRM 8'h10
`define OPC_OTP_READ 8'hAF
`define OPC_READ_CONFIRM 8'h30
`define OPC_RND_OUT 8'h05
`define OPC_RND_CONFIRM 8'hE0

// Fixed address code of the lock sequence, first cycle to last.
`define LOCK_ADDR0 8'h00
`define LOCK_ADDR1 8'h00
`define LOCK_ADDR2 8'h01
`define LOCK_ADDR3 8'h00

// Valid one-time page numbers.
`define OTP_PAGE_FIRST 8'h02
`define OTP_PAGE_LAST 8'h0B

// Status byte fields.
`define STAT_PASS_FAIL_BIT 0
`define STAT_READY_BIT 5
`define STAT_PROTECT_BIT 7

// Times in their own units.
`define WP_SETUP_NS 100
`define WE_HIGH_TO_BUSY_NS 100
`define WE_HIGH_TO_RE_NS 80
`define POWER_WAIT_US 100
`define RESET_BUSY_MAX_US 1000

// Cycle counts: least times round up, longest times round down.
`define WP_SETUP_CYC ((`WP_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_CYC ((`WE_HIGH_TO_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WHR_CYC ((`WE_HIGH_TO_RE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_WAIT_CYC ((`POWER_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_BUSY_MAX_CYC ((`RESET_BUSY_MAX_US * 1000) / `CLK_PERIOD_NS)

// Read enable low time in cycles, long enough for the three-stage input sampler.
`define RE_LOW_CYC 4

// Read data buffer shape.
`define RD_FIFO_WIDTH 8
`define RD_FIFO_DEPTH 32

`endif

// [pkg/nand_otp_host_pkg.sv]
// Types shared by the NAND one-time area host.
// Assumes nothing of its surroundings.
package nand_otp_host_pkg;

  // Operations a user may request.
  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_LOCK = 3'h1,
    OP_READ = 3'h2,
    OP_RND_OUT = 3'h3,
    OP_STATUS = 3'h4
  } op_t;

  // Controller states, one-hot.
  typedef enum logic [7:0] {
    ST_POWER = 8'b0000_0001,
    ST_IDLE = 8'b0000_0010,
    ST_WP_SETUP = 8'b0000_0100,
    ST_WR_LOW = 8'b0000_1000,
    ST_WR_HIGH = 8'b0001_0000,
    ST_WAIT = 8'b0010_0000,
    ST_RD_LOW = 8'b0100_0000,
    ST_RD_HIGH = 8'b1000_0000
  } state_t;

endpackage : nand_otp_host_pkg

// [hdl/nand_otp_host.sv]
// NAND host controller for power-up, reset, one-time area lock and read.
// Assumes a NAND device on the pins and a user that follows READY_OUT.
// Contract
// - Lock is A5h, 00-00-01-00, 10h.
// - Read is AFh, column, page 02h-0Bh, 30h.
// - Reset before cache read after one-time read.
// - Write protect settled setup time before command.
// - Write protect stable until operation finishes.
// - First command after power-on is reset.
// - Before first reset, wait ready or 100us.
// - Power-on reset busy ends within 1ms.
// - Hold write protect low during power transitions.
`include "nand_otp_host_cfg.svh"

// Byte buffer between the read pins and the user; back-pressure stalls read enable.
module rd_fifo #(
  parameter int WIDTH = `RD_FIFO_WIDTH,
  parameter int DEPTH = `RD_FIFO_DEPTH
) (
  // Clocking.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // Fill side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit.
  always_comb begin
    in_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid_out = (wr_ptr != rd_ptr);
    out_data_out = mem[rd_ptr[AW-1:0]];
    push = in_valid_in && in_ready_out && en_in;
    pop = out_valid_out && out_ready_in && en_in;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Storage holds no reset; only the pointers do.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
endmodule : rd_fifo

module nand_otp_host #(
  parameter int BUSY_TIMEOUT_CYC = `RESET_BUSY_MAX_CYC
) (
  // Clock, reset and clock enable.
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  // User command port.
  input wire logic START_IN,
  input wire nand_otp_host_pkg::op_t OP_IN,
  input wire logic [11:0] COLUMN_IN,
  input wire logic [7:0] PAGE_IN,
  input wire logic [11:0] LENGTH_IN,
  output logic READY_OUT,
  output logic DONE_OUT,
  output logic ERROR_OUT,
  output logic FAIL_OUT,
  output logic LOCKED_OUT,
  output logic INIT_DONE_OUT,
  output logic [7:0] STATUS_OUT,
  // Read data stream.
  output logic RD_VALID_OUT,
  input wire logic RD_READY_IN,
  output logic [7:0] RD_DATA_OUT,
  // NAND pins.
  output logic NAND_CE_N_OUT,
  output logic NAND_CLE_OUT,
  output logic NAND_ALE_OUT,
  output logic NAND_WE_N_OUT,
  output logic NAND_RE_N_OUT,
  output logic NAND_WP_N_OUT,
  input wire logic [7:0] NAND_IO_IN,
  output logic [7:0] NAND_IO_OUT,
  output logic NAND_IO_OE_OUT,
  input wire logic READY_BUSY_N_IN
);
  import nand_otp_host_pkg::*;

  state_t state, next_state;
  op_t op, next_op;
  logic [2:0] step, next_step;
  logic [15:0] cnt, next_cnt;
  logic [11:0] remain, next_remain;
  logic [11:0] col, next_col;
  logic [7:0] page, next_page;
  logic [7:0] status, next_status;
  logic init_done, next_init_done;
  logic done, next_done;
  logic err, next_err;
  logic wp_n, next_wp_n;
  logic ce_n, cle, ale, we_n, re_n, io_oe;
  logic next_ce_n, next_cle, next_ale, next_we_n, next_re_n, next_io_oe;
  logic [7:0] io_out, next_io_out;
  logic [2:0] rb_s;
  logic [7:0] io_s [3];
  logic rb_ready;
  logic fifo_valid, fifo_ready;
  logic [9:0] item;
  logic [9:0] next_item;

  // Bus item for a step: {last, is_address, byte}.
  function automatic logic [9:0] seq_item(op_t o, logic [2:0] i, logic [11:0] c,
                                          logic [7:0] p);
    logic [9:0] r;
    r = {2'b10, `OPC_STATUS};
    case (o)
      OP_RESET: r = {2'b10, `OPC_RESET}; // The user issues this before any cache read.
      OP_LOCK: begin
        case (i)
          3'd0: r = {2'b00, `OPC_LOCK};
          3'd1: r = {2'b01, `LOCK_ADDR0};
          3'd2: r = {2'b01, `LOCK_ADDR1};
          3'd3: r = {2'b01, `LOCK_ADDR2};
          3'd4: r = {2'b01, `LOCK_ADDR3};
          default: r = {2'b10, `OPC_LOCK_CONFIRM};
        endcase
      end
      OP_READ: begin
        case (i)
          3'd0: r = {2'b00, `OPC_OTP_READ};
          3'd1: r = {2'b01, c[7:0]};
          3'd2: r = {2'b01, 4'h0, c[11:8]};
          3'd3: r = {2'b01, p};
          3'd4: r = {2'b01, 8'h00};
          default: r = {2'b10, `OPC_READ_CONFIRM};
        endcase
      end
      OP_RND_OUT: begin
        case (i)
          3'd0: r = {2'b00, `OPC_RND_OUT};
          3'd1: r = {2'b01, c[7:0]};
          3'd2: r = {2'b01, 4'h0, c[11:8]};
          default: r = {2'b10, `OPC_RND_CONFIRM};
        endcase
      end
      default: r = {2'b10, `OPC_STATUS};
    endcase
    return r;
  endfunction : seq_item

  // Three-stage samplers; ready counts only once the second and third stages are both high.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rb_s <= 3'b000;
      io_s[0] <= 8'h00;
      io_s[1] <= 8'h00;
      io_s[2] <= 8'h00;
    end else if (CLK_EN_IN) begin
      rb_s <= {rb_s[1:0], READY_BUSY_N_IN};
      io_s[0] <= NAND_IO_IN;
      io_s[1] <= io_s[0];
      io_s[2] <= io_s[1];
    end
  end
  assign rb_ready = rb_s[1] && rb_s[2];

  // Sequencer: commands, busy waits, status and data reads.
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_cnt = cnt;
    next_remain = remain;
    next_col = col;
    next_page = page;
    next_status = status;
    next_init_done = init_done;
    next_done = 1'b0;
    next_err = err;
    next_wp_n = wp_n;
    item = seq_item(op, step, col, page);
    case (state)
      // Wait for ready or the power wait, with write protect held low.
      ST_POWER: begin
        next_wp_n = 1'b0;
        next_cnt = cnt + 16'd1;
        if (rb_ready || cnt >= 16'(`POWER_WAIT_CYC - 1)) begin
          next_op = OP_RESET;
          next_step = 3'd0;
          next_state = ST_WR_LOW;
        end
      end
      ST_IDLE: begin
        if (START_IN && init_done) begin
          next_op = OP_IN;
          next_step = 3'd0;
          next_col = COLUMN_IN;
          next_page = PAGE_IN;
          next_remain = LENGTH_IN;
          next_err = 1'b0;
          next_cnt = 16'd0;
          if (OP_IN == OP_READ && (PAGE_IN < `OTP_PAGE_FIRST || PAGE_IN > `OTP_PAGE_LAST)) begin
            next_err = 1'b1;
            next_done = 1'b1;
          end else if (OP_IN == OP_LOCK) begin
            next_wp_n = 1'b1;
            next_state = ST_WP_SETUP;
          end else begin
            next_state = ST_WR_LOW;
          end
        end
      end
      // Write protect settles before the first command is latched.
      ST_WP_SETUP: begin
        next_cnt = cnt + 16'd1;
        if (cnt >= 16'(`WP_SETUP_CYC - 1)) begin
          next_state = ST_WR_LOW;
        end
      end
      ST_WR_LOW: next_state = ST_WR_HIGH;
      ST_WR_HIGH: begin
        next_step = step + 3'd1;
        next_cnt = 16'd0;
        next_state = item[9] ? ST_WAIT : ST_WR_LOW;
      end
      // Busy wait with timeout; no command goes out while the device is busy.
      ST_WAIT: begin
        next_cnt = cnt + 16'd1;
        if (cnt < 16'(`WB_CYC + `WHR_CYC)) begin
          next_state = ST_WAIT;
        end else if ((op == OP_RESET || op == OP_LOCK || op == OP_READ) && !rb_ready) begin
          if (cnt >= 16'(BUSY_TIMEOUT_CYC)) begin
            next_err = 1'b1;
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
        end else if (op == OP_RESET || op == OP_LOCK) begin
          next_op = OP_STATUS;
          next_step = 3'd0;
          next_state = ST_WR_LOW;
        end else if (op == OP_STATUS) begin
          next_remain = 12'd1;
          next_cnt = 16'd0;
          next_state = ST_RD_LOW;
        end else if (remain == 12'd0) begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end else if (fifo_ready) begin
          next_cnt = 16'd0;
          next_state = ST_RD_LOW;
        end
      end
      // Read enable low long enough for the sampler, then capture.
      ST_RD_LOW: begin
        next_cnt = cnt + 16'd1;
        if (cnt >= 16'(`RE_LOW_CYC - 1)) begin
          if (op == OP_STATUS) begin
            next_status = io_s[2];
          end
          next_remain = remain - 12'd1;
          next_state = ST_RD_HIGH;
        end
      end
      ST_RD_HIGH: begin
        next_cnt = 16'd0;
        if (remain == 12'd0) begin
          next_done = 1'b1;
          next_init_done = 1'b1;
          next_wp_n = 1'b0;
          next_state = ST_IDLE;
        end else if (fifo_ready) begin
          next_state = ST_RD_LOW;
        end
      end
      default: next_state = ST_POWER;
    endcase
    // Pin levels follow the state being entered.
    next_ce_n = (next_state == ST_POWER) || (next_state == ST_IDLE);
    next_we_n = (next_state != ST_WR_LOW);
    next_re_n = (next_state != ST_RD_LOW);
    next_io_oe = (next_state == ST_WR_LOW) || (next_state == ST_WR_HIGH);
    next_item = seq_item(next_op, next_step, next_col, next_page);
    next_io_out = next_io_oe ? next_item[7:0] : 8'h00;
    next_cle = next_io_oe && !next_item[8];
    next_ale = next_io_oe && next_item[8];
  end

  // Register every piece of control state; the clock enable freezes all of it.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_POWER;
      op <= OP_RESET;
      step <= 3'd0;
      cnt <= 16'd0;
      remain <= 12'd0;
      col <= 12'd0;
      page <= 8'h00;
      status <= 8'h00;
      init_done <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      wp_n <= 1'b0;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_oe <= 1'b0;
      io_out <= 8'h00;
    end else if (CLK_EN_IN) begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      cnt <= next_cnt;
      remain <= next_remain;
      col <= next_col;
      page <= next_page;
      status <= next_status;
      init_done <= next_init_done;
      done <= next_done;
      err <= next_err;
      wp_n <= next_wp_n;
      ce_n <= next_ce_n;
      cle <= next_cle;
      ale <= next_ale;
      we_n <= next_we_n;
      re_n <= next_re_n;
      io_oe <= next_io_oe;
      io_out <= next_io_out;
    end
  end

  // Data bytes enter the buffer at the end of each read enable low phase.
  rd_fifo #(
    .WIDTH(`RD_FIFO_WIDTH),
    .DEPTH(`RD_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .en_in(CLK_EN_IN),
    .in_valid_in(fifo_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(io_s[2]),
    .out_valid_out(RD_VALID_OUT),
    .out_ready_in(RD_READY_IN),
    .out_data_out(RD_DATA_OUT)
  );
  assign fifo_valid = (state == ST_RD_LOW) && (op != OP_STATUS) &&
                      (cnt >= 16'(`RE_LOW_CYC - 1));

  // User-facing outputs and NAND pins.
  assign READY_OUT = (state == ST_IDLE) && init_done;
  assign DONE_OUT = done;
  assign ERROR_OUT = err;
  assign FAIL_OUT = status[`STAT_PASS_FAIL_BIT];
  assign LOCKED_OUT = !status[`STAT_PROTECT_BIT];
  assign INIT_DONE_OUT = init_done;
  assign STATUS_OUT = status;
  assign NAND_CE_N_OUT = ce_n;
  assign NAND_CLE_OUT = cle;
  assign NAND_ALE_OUT = ale;
  assign NAND_WE_N_OUT = we_n;
  assign NAND_RE_N_OUT = re_n;
  assign NAND_WP_N_OUT = wp_n;
  assign NAND_IO_OUT = io_out;
  assign NAND_IO_OE_OUT = io_oe;
endmodule : nand_otp_host

// [sim/nand_otp_host_asserts.sv]
// Pin-level checks for the one-time area NAND host.
// Bound to nand_otp_host; sees only its ports and one clock domain.
module nand_otp_host_chk (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  // User side.
  input wire logic START_IN,
  input wire nand_otp_host_pkg::op_t OP_IN,
  input wire logic [7:0] PAGE_IN,
  input wire logic READY_OUT,
  input wire logic DONE_OUT,
  input wire logic ERROR_OUT,
  // NAND pins.
  input wire logic NAND_CLE_OUT,
  input wire logic NAND_ALE_OUT,
  input wire logic NAND_WE_N_OUT,
  input wire logic NAND_WP_N_OUT,
  input wire logic [7:0] NAND_IO_OUT,
  input wire logic READY_BUSY_N_IN
);
  import nand_otp_host_pkg::*;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  // Power-up bookkeeping; the wait counter saturates so it never wraps past the limit.
  logic sent, rb_seen, next_sent, next_rb_seen;
  logic [10:0] waited, next_waited;
  always_comb begin
    next_sent = sent | ~NAND_WE_N_OUT;
    next_rb_seen = rb_seen | READY_BUSY_N_IN;
    next_waited = (waited == 11'h7D0) ? waited : waited + 11'h001;
  end
  // Registers of the bookkeeping.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sent <= 1'b0;
      rb_seen <= 1'b0;
      waited <= 11'h000;
    end else begin
      sent <= next_sent;
      rb_seen <= next_rb_seen;
      waited <= next_waited;
    end
  end

  // Latch cycles, seen where the write enable falls.
  sequence s_cmd(logic [7:0] v);
    $fell(NAND_WE_N_OUT) && NAND_CLE_OUT && NAND_IO_OUT == v;
  endsequence
  sequence s_adr(logic [7:0] lo, logic [7:0] hi);
    $fell(NAND_WE_N_OUT) && NAND_ALE_OUT && NAND_IO_OUT >= lo && NAND_IO_OUT <= hi;
  endsequence

  property p_lock_seq;
    s_cmd(8'hA5) |-> ##2 s_adr(8'h00, 8'h00) ##2 s_adr(8'h00, 8'h00) ##2 s_adr(8'h01, 8'h01)
      ##2 s_adr(8'h00, 8'h00) ##2 s_cmd(8'h10);
  endproperty
  a_lock_seq: assert property (p_lock_seq) else $error("lock sequence malformed");
  property p_read_seq;
    s_cmd(8'hAF) |-> ##2 s_adr(8'h00, 8'hFF) ##2 s_adr(8'h00, 8'h0F) ##2 s_adr(8'h02, 8'h0B)
      ##2 s_adr(8'h00, 8'h00) ##2 s_cmd(8'h30);
  endproperty
  a_read_seq: assert property (p_read_seq) else $error("read sequence malformed");
  property p_wp_setup;
    s_cmd(8'hA5) |-> $past(NAND_WP_N_OUT, 2);
  endproperty
  a_wp_setup: assert property (p_wp_setup) else $error("write protect setup short");
  property p_wp_stable;
    !READY_BUSY_N_IN && NAND_WP_N_OUT |=> NAND_WP_N_OUT;
  endproperty
  a_wp_stable: assert property (p_wp_stable) else $error("write protect moved while busy");
  property p_busy_cmd;
    $fell(NAND_WE_N_OUT) && !READY_BUSY_N_IN |->
      NAND_CLE_OUT && (NAND_IO_OUT == 8'h70 || NAND_IO_OUT == 8'hFF);
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("command while busy");
  property p_first;
    $fell(NAND_WE_N_OUT) && !sent |-> NAND_CLE_OUT && NAND_IO_OUT == 8'hFF;
  endproperty
  a_first: assert property (p_first) else $error("first command not reset");
  property p_power;
    $fell(NAND_WE_N_OUT) && !sent |-> rb_seen || waited == 11'h7D0;
  endproperty
  a_power: assert property (p_power) else $error("first command too early");
  property p_bad_page;
    START_IN && CLK_EN_IN && READY_OUT && OP_IN == OP_READ && (PAGE_IN < 8'h02 ||
      PAGE_IN > 8'h0B) |-> ##[1:2] DONE_OUT && ERROR_OUT;
  endproperty
  a_bad_page: assert property (p_bad_page) else $error("bad page not refused");
  property p_wp_idle;
    READY_OUT |-> !NAND_WP_N_OUT;
  endproperty
  a_wp_idle: assert property (p_wp_idle) else $error("write protect open while idle");
endmodule : nand_otp_host_chk

bind nand_otp_host nand_otp_host_chk u_chk (
  .CLK_IN, .RST_IN, .CLK_EN_IN, .START_IN, .OP_IN, .PAGE_IN, .READY_OUT, .DONE_OUT,
  .ERROR_OUT, .NAND_CLE_OUT, .NAND_ALE_OUT, .NAND_WE_N_OUT, .NAND_WP_N_OUT, .NAND_IO_OUT,
  .READY_BUSY_N_IN
);

// [sim/nand_dev_model.sv]
// Behavioural one-time area NAND device for the host bench.
// Assumes host pins as inputs; busy times are shortened through parameters (ns).
module nand_dev_model #(
  parameter int T_PWR = 2000,
  parameter int T_RST = 3000,
  parameter int T_RD = 2000,
  parameter int T_PROG = 5000
) (
  // Host pins.
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] din,
  // Device outputs and count of host faults.
  output logic [7:0] dout,
  output logic ready_busy_n,
  output int errs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic locked = 1'b0, fail = 1'b0, stat = 1'b0, started = 1'b0;
  logic [7:0] cmd = 8'h00, page = 8'h02, q = 8'h00;
  logic [7:0] adr [4];
  logic [11:0] col = 12'h000;
  int na = 0;
  realtime t_wp = 0;

  // Ready/busy stays low until supply settles.
  initial begin
    errs = 0;
    ready_busy_n = 1'b0;
    #(T_PWR) ready_busy_n = 1'b1;
  end
  // Each lock confirm, read confirm and reset schedules its own ready edge, so latching never blocks.
  task automatic go_busy(int t);
    ready_busy_n = 1'b0;
    ready_busy_n <= #(t) 1'b1;
  endtask : go_busy
  // Write protect must stay put from the lock opcode until the lock ends.
  always @(wp_n) begin
    t_wp = $realtime;
    if (cmd == 8'hA5 || (cmd == 8'h10 && !ready_busy_n)) errs++;
  end
  // Command and address latch on the write enable rising edge.
  always @(posedge we_n) if (!ce_n && ale) begin
    adr[na % 4] = din;
    na++;
  end else if (!ce_n && cle) begin
    if (!started && din != 8'hFF) errs++;
    if (!ready_busy_n && din != 8'h70 && din != 8'hFF) errs++;
    started = 1'b1;
    stat = (din == 8'h70);
    case (din)
      8'hA5: if (!wp_n || $realtime - t_wp < 100) errs++;
      8'h10: if (cmd == 8'hA5) begin
        if ({adr[0], adr[1], adr[2], adr[3]} != 32'h0000_0100 || na != 4) errs++;
        fail = ~wp_n;
        locked = locked | wp_n;
        go_busy(T_PROG);
      end
      8'h30: if (cmd == 8'hAF) begin
        page = adr[2];
        col = {adr[1][3:0], adr[0]};
        if (page < 8'h02 || page > 8'h0B || na != 4) errs++;
        go_busy(T_RD);
      end
      8'hE0: col = {adr[1][3:0], adr[0]};
      8'hFF: go_busy(T_RST);
      default: ;
    endcase
    if (din != 8'h70) begin
      cmd = din;
      na = 0;
    end
  end
  // Data leaves on the read enable falling edge; the pointer steps afterwards.
  always @(negedge re_n) if (!ce_n) begin
    q = stat ? {~locked, ready_busy_n, ready_busy_n, 4'h0, fail} : col[7:0] + page;
    if (!stat) col++;
  end
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign dout = (!re_n && !ce_n) ? q : ~q;
endmodule : nand_dev_model

// [sim/tb_nand_otp_host.sv]
// Self-checking bench for the one-time area NAND host against a device model.
// Assumes package, design, checker and device model are compiled first.
module tb_nand_otp_host;
  timeunit 1ns;
  timeprecision 100ps;
  import nand_otp_host_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, start = 1'b0, rd_ready = 1'b0;
  op_t op = OP_STATUS;
  logic [11:0] column = 12'h000, length = 12'h000;
  logic [7:0] page = 8'h00;
  logic ready, done, error, fail, locked, init_done, rd_valid;
  logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy_n;
  logic [7:0] status, rd_data, io_out, dev_out;
  wire [7:0] io_bus = io_oe ? io_out : dev_out;
  int errs, bad_count = 0, n_checks = 0;
  int done_cnt = 0, done_mark = 0;

  nand_otp_host #(.BUSY_TIMEOUT_CYC(400)) dut (
    .CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(clk_en),
    .START_IN(start), .OP_IN(op), .COLUMN_IN(column), .PAGE_IN(page), .LENGTH_IN(length),
    .READY_OUT(ready), .DONE_OUT(done), .ERROR_OUT(error), .FAIL_OUT(fail),
    .LOCKED_OUT(locked), .INIT_DONE_OUT(init_done), .STATUS_OUT(status),
    .RD_VALID_OUT(rd_valid), .RD_READY_IN(rd_ready), .RD_DATA_OUT(rd_data),
    .NAND_CE_N_OUT(ce_n), .NAND_CLE_OUT(cle), .NAND_ALE_OUT(ale), .NAND_WE_N_OUT(we_n),
    .NAND_RE_N_OUT(re_n), .NAND_WP_N_OUT(wp_n), .NAND_IO_IN(io_bus), .NAND_IO_OUT(io_out),
    .NAND_IO_OE_OUT(io_oe), .READY_BUSY_N_IN(ready_busy_n)
  );
  nand_dev_model dev (.ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .din(io_bus), .dout(dev_out),
    .ready_busy_n, .errs);

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  // Counts done pulses at each rising edge, so a one-cycle pulse is never lost between polls.
  always @(posedge clk) begin
    if (done === 1'b1) done_cnt++;
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Bounded wait on a flag, sampled on the falling edge where it has settled.
  task automatic await(string what, int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge clk);
      if ((what == "ready" ? ready :
          what == "done" ? (done_cnt != done_mark) : what == "valid" ? rd_valid :
          init_done) === 1'b1) break;
    end
    if (i == lim) begin
      chk(what, 8'h01, 8'h00);
      wrap_up();
    end
  endtask : await

  task automatic start_op(op_t o, logic [11:0] c, logic [7:0] p, logic [11:0] n);
    await("ready", 4000);
    done_mark = done_cnt;
    @(posedge clk);
    op <= o;
    column <= c;
    page <= p;
    length <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask : start_op

  // Takes bytes one handshake at a time, so the buffer sees a slow consumer.
  task automatic get_bytes(int n, logic [7:0] p, logic [11:0] c);
    for (int k = 0; k < n; k++) begin
      await("valid", 4000);
      chk("rd_data", c[7:0] + p + 8'(k), rd_data);
      @(posedge clk);
      rd_ready <= 1'b1;
      @(posedge clk);
      rd_ready <= 1'b0;
    end
  endtask : get_bytes

  task automatic do_read(logic [7:0] p, logic [11:0] c, int n);
    start_op(OP_READ, c, p, 12'(n));
    get_bytes(n, p, c);
    await("done", 4000);
    chk("error", 8'h00, {7'h00, error});
  endtask : do_read

  task automatic t_init();
    await("init", 6000);
    chk("status", 8'hE0, status);
    chk("locked", 8'h00, {7'h00, locked});
    chk("wp_n", 8'h00, {7'h00, wp_n});
    start_op(OP_STATUS, 12'h000, 8'h00, 12'h000);
    await("done", 400);
    chk("status", 8'hE0, status);
    chk("fail", 8'h00, {7'h00, fail});
    $display("test init done");
  endtask : t_init

  // Buffer fills while the consumer stalls; the host must hold read enable high.
  task automatic t_fifo();
    start_op(OP_READ, 12'h000, 8'h02, 12'h028);
    repeat (400) @(negedge clk);
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("re_n", 8'h01, {7'h00, re_n});
    // A frozen clock enable must not pop the buffer even while the consumer asks.
    @(posedge clk);
    clk_en <= 1'b0;
    rd_ready <= 1'b1;
    repeat (5) @(posedge clk);
    clk_en <= 1'b1;
    rd_ready <= 1'b0;
    get_bytes(40, 8'h02, 12'h000);
    await("done", 4000);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_reads();
    do_read(8'h0B, 12'h83E, 2);
    do_read(8'h05, 12'h100, 3);
    start_op(OP_RND_OUT, 12'h007, 8'h05, 12'h002);
    get_bytes(2, 8'h05, 12'h007);
    await("done", 4000);
    for (int i = 0; i < 2; i++) begin
      start_op(OP_READ, 12'h000, i ? 8'h0C : 8'h01, 12'h004);
      await("done", 50);
      chk("error", 8'h01, {7'h00, error});
      chk("rd_valid", 8'h00, {7'h00, rd_valid});
    end
    $display("test reads done");
  endtask : t_reads

  task automatic t_lock();
    for (int i = 0; i < 2; i++) begin
      start_op(OP_LOCK, 12'h000, 8'h00, 12'h000);
      await("done", 4000);
      chk("status", 8'h60, status);
      chk("locked", 8'h01, {7'h00, locked});
      chk("wp_n", 8'h00, {7'h00, wp_n});
      do_read(8'h03, 12'h010, 2);
    end
    start_op(OP_RESET, 12'h000, 8'h00, 12'h000);
    await("done", 4000);
    chk("error", 8'h00, {7'h00, error});
    $display("test lock done");
  endtask : t_lock

  // Reset in mid-read; the host must start over with the power-up order.
  task automatic t_midreset();
    start_op(OP_READ, 12'h000, 8'h04, 12'h008);
    repeat (30) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    await("init", 6000);
    chk("status", 8'h60, status);
    chk("locked", 8'h01, {7'h00, locked});
    chk("rd_valid", 8'h00, {7'h00, rd_valid});
    $display("test midreset done");
  endtask : t_midreset

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_fifo();
    t_reads();
    t_lock();
    t_midreset();
    chk("host_faults", 8'h00, 8'(errs));
    wrap_up();
  end
endmodule : tb_nand_otp_host
